// ### vobc_pkg.sv
// Register map, field layout and reset values of the overlay config bank
package vobc_pkg;

  // Register address width and byte addresses
  localparam int unsigned ADDR_W        = 6;
  localparam logic [5:0]  OFS_ORIGIN    = 6'h00;
  localparam logic [5:0]  OFS_SIZE      = 6'h04;
  localparam logic [5:0]  OFS_ADDR_Y    = 6'h08;
  localparam logic [5:0]  OFS_ADDR_CB   = 6'h0c;
  localparam logic [5:0]  OFS_ADDR_CR   = 6'h10;
  localparam logic [5:0]  OFS_ADDR_OVL  = 6'h14;
  localparam logic [5:0]  OFS_CSTRIDE   = 6'h18;
  localparam logic [5:0]  OFS_YSTRIDE   = 6'h1c;
  localparam logic [5:0]  OFS_ECTL      = 6'h20;

  // Origin / size fields: row, column, alpha weight
  localparam int unsigned ROW_LSB       = 0;
  localparam int unsigned ROW_W         = 12;
  localparam int unsigned COL_LSB       = 12;
  localparam int unsigned COL_W         = 12;
  localparam int unsigned ALPHA_LSB     = 24;
  localparam int unsigned ALPHA_W       = 8;

  // Stride fields, two per register
  localparam int unsigned STRIDE_W      = 16;
  localparam int unsigned STRIDE_LO_LSB = 0;
  localparam int unsigned STRIDE_HI_LSB = 16;

  // Buffer length and alignment in streaming mode
  localparam int unsigned LEN_W         = 24;
  localparam int unsigned ALIGN_BITS    = 6;

  // Enhanced control fields
  localparam int unsigned EC_ENABLE     = 0;
  localparam int unsigned EC_FULL_BLEND = 1;
  localparam int unsigned EC_CLIP       = 2;
  localparam int unsigned EC_SYNC_STRM  = 3;
  localparam int unsigned EC_FIELD_SYNC = 4;
  localparam int unsigned EC_GENLOCK    = 5;
  localparam int unsigned EC_KEY        = 6;
  localparam int unsigned EC_FEAT_W     = 7;
  localparam int unsigned REV_LSB       = 28;
  localparam int unsigned REV_W         = 4;
  // Revision code: value is arbitrary
  localparam logic [3:0]  REVISION      = 4'h2;

  // Reset values
  localparam logic [31:0] RST_CFG       = 32'h0000_0000;
  localparam logic [6:0]  RST_FEAT      = 7'h00;

  // Legacy blend levels 0, 25, 50, 75, 100 percent
  localparam logic [7:0]  LVL_0         = 8'h00;
  localparam logic [7:0]  LVL_25        = 8'h40;
  localparam logic [7:0]  LVL_50        = 8'h80;
  localparam logic [7:0]  LVL_75        = 8'hc0;
  localparam logic [7:0]  LVL_100       = 8'hff;
  localparam logic [7:0]  THR_12        = 8'h20;
  localparam logic [7:0]  THR_37        = 8'h60;
  localparam logic [7:0]  THR_62        = 8'ha0;
  localparam logic [7:0]  THR_87        = 8'he0;

  // Transfer modes, one-hot
  typedef enum logic [2:0] {
    VOBC_REFRESH = 3'b001,
    VOBC_STREAM  = 3'b010,
    VOBC_MESSAGE = 3'b100
  } vobc_mode_t;

endpackage

// ### vobc_regs.sv
// Overlay, buffer and stride configuration bank of the video output unit
// Behaviour
// - Overlay column gives the first overlay pixel, zero is the image's first pixel, and it is even.
// - For 4:2:2+alpha overlays the weight is the first one when the alpha bit is 1, else the second.
// - Second address is the Cb start in refresh, a 64-byte aligned buffer in streaming, unused in messaging.
// - Third address is the Cr start in refresh, else a 24-bit first length, a multiple of 64 when streaming.
// - In refresh the overlay address is the overlay start, taken up at the next frame boundary.
// - In streaming the overlay address is a second length, a multiple of 64, unused in messaging.
// - Luma, Cb, Cr and overlay each have a 16-bit unsigned line stride in bytes.
// - Enhanced features are off after reset until software turns them on.
// - The top four bits of the enhanced control register read the revision.
// - An enabled enhanced feature replaces its legacy counterpart, never runs beside it.
// - With the enhanced enable bit at 0, its reset value, the unit acts as the legacy one.
`timescale 1ns/10ps
module vobc_regs
  import vobc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  // Register access port
  input  wire logic [ADDR_W-1:0]    reg_addr_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  input  wire logic [31:0]          reg_wdata_i,
  output logic      [31:0]          reg_rdata_o,
  output logic                      reg_rvalid_o,
  output logic                      reg_err_o,
  // Datapath context
  input  wire logic [2:0]           mode_i,
  input  wire logic                 frame_start_i,
  input  wire logic                 alpha_bit_i,
  // Overlay placement and blend
  output logic [ROW_W-1:0]          overlay_first_row_o,
  output logic [COL_W-1:0]          overlay_first_column_o,
  output logic [ROW_W-1:0]          overlay_height_o,
  output logic [COL_W-1:0]          overlay_width_o,
  output logic [ALPHA_W-1:0]        blend_weight_o,
  // Buffer addresses and lengths
  output logic [31:0]               luma_plane_start_o,
  output logic [31:0]               cb_plane_start_o,
  output logic [31:0]               cr_plane_start_o,
  output logic [31:0]               ovl_plane_start_o,
  output logic [31:0]               second_buffer_start_o,
  output logic [LEN_W-1:0]          first_buffer_length_o,
  output logic [LEN_W-1:0]          second_buffer_length_o,
  // Line strides
  output logic [STRIDE_W-1:0]       luma_line_stride_o,
  output logic [STRIDE_W-1:0]       cb_line_stride_o,
  output logic [STRIDE_W-1:0]       cr_line_stride_o,
  output logic [STRIDE_W-1:0]       ovl_line_stride_o,
  // Enhanced feature controls
  output logic                      enhanced_features_on_o,
  output logic                      full_blend_o,
  output logic                      clip_enable_o,
  output logic                      sync_streaming_o,
  output logic                      field_sync_o,
  output logic                      genlock_o,
  output logic                      key_enable_o
);

  // Stored registers and combinational helpers
  logic [31:0]           overlay_origin_alpha_high;
  logic [31:0]           overlay_size_alpha_low;
  logic [31:0]           luma_or_first_buffer_address;
  logic [31:0]           cb_or_second_buffer_address;
  logic [31:0]           cr_address_or_first_length;
  logic [31:0]           overlay_address_or_second_length;
  logic [31:0]           chroma_line_strides;
  logic [31:0]           luma_overlay_line_strides;
  logic [EC_FEAT_W-1:0]  enhanced_feat;
  logic [31:0]           ovl_addr_live;
  logic [31:0]           next_rdata;
  logic                  next_hit;
  logic [ALPHA_W-1:0]    raw_weight;
  logic [ALPHA_W-1:0]    legacy_weight;
  logic [ALPHA_W-1:0]    next_weight;
  logic                  feat_on;
  logic [31:0]           align_mask;
  vobc_mode_t            mode;

  assign mode       = vobc_mode_t'(mode_i);
  assign feat_on    = enhanced_feat[EC_ENABLE];
  assign align_mask = ~((32'h0000_0001 << ALIGN_BITS) - 32'h0000_0001);

  // Register writes; each address owns its own storage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overlay_origin_alpha_high        <= RST_CFG;
      overlay_size_alpha_low           <= RST_CFG;
      luma_or_first_buffer_address     <= RST_CFG;
      cb_or_second_buffer_address      <= RST_CFG;
      cr_address_or_first_length       <= RST_CFG;
      overlay_address_or_second_length <= RST_CFG;
      chroma_line_strides              <= RST_CFG;
      luma_overlay_line_strides        <= RST_CFG;
      enhanced_feat                    <= RST_FEAT;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_ORIGIN:   overlay_origin_alpha_high        <= reg_wdata_i;
        OFS_SIZE:     overlay_size_alpha_low           <= reg_wdata_i;
        OFS_ADDR_Y:   luma_or_first_buffer_address     <= reg_wdata_i;
        OFS_ADDR_CB:  cb_or_second_buffer_address      <= reg_wdata_i;
        OFS_ADDR_CR:  cr_address_or_first_length       <= reg_wdata_i;
        OFS_ADDR_OVL: overlay_address_or_second_length <= reg_wdata_i;
        OFS_CSTRIDE:  chroma_line_strides              <= reg_wdata_i;
        OFS_YSTRIDE:  luma_overlay_line_strides        <= reg_wdata_i;
        OFS_ECTL:     enhanced_feat <= reg_wdata_i[EC_FEAT_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read mux; undefined control bits read zero, revision is fixed
  always_comb begin
    next_hit   = 1'b1;
    next_rdata = 32'h0000_0000;
    case (reg_addr_i)
      OFS_ORIGIN:   next_rdata = overlay_origin_alpha_high;
      OFS_SIZE:     next_rdata = overlay_size_alpha_low;
      OFS_ADDR_Y:   next_rdata = luma_or_first_buffer_address;
      OFS_ADDR_CB:  next_rdata = cb_or_second_buffer_address;
      OFS_ADDR_CR:  next_rdata = cr_address_or_first_length;
      OFS_ADDR_OVL: next_rdata = overlay_address_or_second_length;
      OFS_CSTRIDE:  next_rdata = chroma_line_strides;
      OFS_YSTRIDE:  next_rdata = luma_overlay_line_strides;
      OFS_ECTL: begin
        next_rdata[REV_LSB +: REV_W]    = REVISION;
        next_rdata[EC_FEAT_W-1:0]       = enhanced_feat;
      end
      default:      next_hit   = 1'b0;
    endcase
  end

  // Read answer one cycle after the strobe, held until the next read
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_hit ? next_rdata : 32'h0000_0000;
    end
  end

  // Read valid is a one-cycle pulse
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // Error pulse flags an access to a hole in the map
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_err_o <= 1'b0;
    end else begin
      reg_err_o <= (reg_rd_i | reg_wr_i) & ~next_hit;
    end
  end

  // Overlay start is frame-synchronous so a mid-frame rewrite cannot tear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovl_addr_live <= RST_CFG;
    end else if (frame_start_i) begin
      ovl_addr_live <= overlay_address_or_second_length;
    end
  end

  // Legacy blending offers only five levels; snap to the nearest
  always_comb begin
    raw_weight = alpha_bit_i ?
      overlay_origin_alpha_high[ALPHA_LSB +: ALPHA_W] :
      overlay_size_alpha_low[ALPHA_LSB +: ALPHA_W];
    if (raw_weight < THR_12) begin
      legacy_weight = LVL_0;
    end else if (raw_weight < THR_37) begin
      legacy_weight = LVL_25;
    end else if (raw_weight < THR_62) begin
      legacy_weight = LVL_50;
    end else if (raw_weight < THR_87) begin
      legacy_weight = LVL_75;
    end else begin
      legacy_weight = LVL_100;
    end
    // Enable alone keeps the legacy levels; full blend needs both bits
    next_weight = (feat_on && enhanced_feat[EC_FULL_BLEND]) ?
      raw_weight : legacy_weight;
  end

  // Overlay placement and blend weight
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      overlay_first_row_o    <= '0;
      overlay_first_column_o <= '0;
      overlay_height_o       <= '0;
      overlay_width_o        <= '0;
      blend_weight_o         <= '0;
    end else begin
      overlay_first_row_o    <=
        overlay_origin_alpha_high[ROW_LSB +: ROW_W];
      // Odd columns would split a chroma pair, so bit 0 is dropped
      overlay_first_column_o <=
        overlay_origin_alpha_high[COL_LSB +: COL_W] & ~12'h001;
      overlay_height_o       <= overlay_size_alpha_low[ROW_LSB +: ROW_W];
      overlay_width_o        <= overlay_size_alpha_low[COL_LSB +: COL_W];
      blend_weight_o         <= next_weight;
    end
  end

  // Mode-dependent meaning of the address registers
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      luma_plane_start_o     <= '0;
      cb_plane_start_o       <= '0;
      cr_plane_start_o       <= '0;
      ovl_plane_start_o      <= '0;
      second_buffer_start_o  <= '0;
      first_buffer_length_o  <= '0;
      second_buffer_length_o <= '0;
    end else begin
      luma_plane_start_o     <= luma_or_first_buffer_address;
      cb_plane_start_o       <= '0;
      cr_plane_start_o       <= '0;
      ovl_plane_start_o      <= '0;
      second_buffer_start_o  <= '0;
      first_buffer_length_o  <= '0;
      second_buffer_length_o <= '0;
      case (mode)
        VOBC_REFRESH: begin
          cb_plane_start_o  <= cb_or_second_buffer_address;
          cr_plane_start_o  <= cr_address_or_first_length;
          ovl_plane_start_o <= ovl_addr_live;
        end
        VOBC_STREAM: begin
          second_buffer_start_o  <=
            cb_or_second_buffer_address & align_mask;
          first_buffer_length_o  <=
            cr_address_or_first_length[LEN_W-1:0] &
            align_mask[LEN_W-1:0];
          second_buffer_length_o <=
            overlay_address_or_second_length[LEN_W-1:0] &
            align_mask[LEN_W-1:0];
        end
        VOBC_MESSAGE: begin
          first_buffer_length_o <=
            cr_address_or_first_length[LEN_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Per-plane line strides
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      luma_line_stride_o <= '0;
      cb_line_stride_o   <= '0;
      cr_line_stride_o   <= '0;
      ovl_line_stride_o  <= '0;
    end else begin
      cb_line_stride_o   <=
        chroma_line_strides[STRIDE_LO_LSB +: STRIDE_W];
      cr_line_stride_o   <= chroma_line_strides[STRIDE_HI_LSB +: STRIDE_W];
      luma_line_stride_o <=
        luma_overlay_line_strides[STRIDE_LO_LSB +: STRIDE_W];
      ovl_line_stride_o  <=
        luma_overlay_line_strides[STRIDE_HI_LSB +: STRIDE_W];
    end
  end

  // Feature bits count only while the master enable is set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enhanced_features_on_o <= 1'b0;
      full_blend_o           <= 1'b0;
      clip_enable_o          <= 1'b0;
      sync_streaming_o       <= 1'b0;
      field_sync_o           <= 1'b0;
      genlock_o              <= 1'b0;
      key_enable_o           <= 1'b0;
    end else begin
      enhanced_features_on_o <= feat_on;
      full_blend_o     <= feat_on & enhanced_feat[EC_FULL_BLEND];
      clip_enable_o    <= feat_on & enhanced_feat[EC_CLIP];
      // Sync streaming has no meaning outside streaming mode
      sync_streaming_o <= feat_on & enhanced_feat[EC_SYNC_STRM] &
                          (mode == VOBC_STREAM);
      field_sync_o     <= feat_on & enhanced_feat[EC_FIELD_SYNC];
      genlock_o        <= feat_on & enhanced_feat[EC_GENLOCK];
      key_enable_o     <= feat_on & enhanced_feat[EC_KEY];
    end
  end

endmodule

// ### vobc_regs_asserts.sv
// Port-level checks of the overlay config bank
`timescale 1ns/10ps
module vobc_regs_asserts
  import vobc_pkg::*;
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              nrst_i,
  // Register access port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic [31:0]       reg_rdata_o,
  input wire logic              reg_rvalid_o,
  input wire logic              reg_err_o,
  // Datapath side
  input wire logic [2:0]        mode_i,
  input wire logic              frame_start_i,
  input wire logic [COL_W-1:0]  overlay_first_column_o,
  input wire logic [31:0]       ovl_plane_start_o,
  input wire logic [31:0]       second_buffer_start_o,
  input wire logic [LEN_W-1:0]  second_buffer_length_o,
  input wire logic              enhanced_features_on_o,
  input wire logic              full_blend_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_ena_write;
    reg_wr_i && reg_addr_i == OFS_ECTL && reg_wdata_i[EC_ENABLE];
  endsequence
  sequence s_msg_held;
    mode_i == VOBC_MESSAGE ##1 mode_i == VOBC_MESSAGE;
  endsequence

  AST_RVALID: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read gave no valid pulse");
  AST_REV: assert property (reg_rd_i && reg_addr_i == OFS_ECTL
    |=> reg_rdata_o[31:28] == REVISION) else $error("bad revision");
  AST_ENA_ON: assert property (s_ena_write |-> ##2
    enhanced_features_on_o) else $error("enable write not seen");
  AST_ENA_CAUSE: assert property ($rose(enhanced_features_on_o) |->
    $past(reg_wr_i && reg_addr_i == OFS_ECTL && reg_wdata_i[0], 2))
    else $error("enable rose without a write");
  AST_GATED: assert property (full_blend_o |-> enhanced_features_on_o)
    else $error("feature on while enable off");
  AST_COL_EVEN: assert property (overlay_first_column_o[0] == 1'b0)
    else $error("odd overlay column");
  // A swap may only follow a frame strobe or a mode change
  AST_OVL_FRAME: assert property ($changed(ovl_plane_start_o) |->
    $past(frame_start_i, 2) || $past(mode_i) != $past(mode_i, 2))
    else $error("overlay start moved mid frame");
  AST_ALIGN: assert property (second_buffer_start_o[5:0] == 6'h0 &&
    second_buffer_length_o[5:0] == 6'h0) else $error("unaligned buffer");
  AST_MSG: assert property (s_msg_held |-> second_buffer_start_o == '0
    && second_buffer_length_o == '0) else $error("stream value in message");
  AST_ERR: assert property (reg_rd_i && reg_addr_i >= 6'h24 |=>
    reg_err_o && reg_rdata_o == 32'h0) else $error("unmapped read");
endmodule

bind vobc_regs vobc_regs_asserts u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .reg_err_o(reg_err_o), .mode_i(mode_i), .frame_start_i(frame_start_i),
  .overlay_first_column_o(overlay_first_column_o),
  .ovl_plane_start_o(ovl_plane_start_o),
  .second_buffer_start_o(second_buffer_start_o),
  .second_buffer_length_o(second_buffer_length_o),
  .enhanced_features_on_o(enhanced_features_on_o),
  .full_blend_o(full_blend_o));

// ### vobc_cpu_model.sv
// Software-side register master for the overlay config bank
`timescale 1ns/10ps
module vobc_cpu_model
  import vobc_pkg::*;
(
  // Clock
  input  wire logic              clk_i,
  // Register access port
  output logic      [ADDR_W-1:0] reg_addr_o,
  output logic                   reg_wr_o,
  output logic                   reg_rd_o,
  output logic      [31:0]       reg_wdata_o,
  input  wire logic [31:0]       reg_rdata_i,
  input  wire logic              reg_rvalid_i,
  input  wire logic              reg_err_i
);
  initial begin
    reg_addr_o = 6'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 32'h0;
  end
  // Released lines flip so a stale value never passes for a driven one
  task automatic idle();
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    reg_wdata_o = ~reg_wdata_o;
  endtask
  // Strobe is left up so a following access runs back to back
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
                    output logic [1:0] v);
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = ~reg_wdata_o;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_addr_o = ~reg_addr_o;
    d = reg_rdata_i;
    v = {reg_err_i, reg_rvalid_i};
  endtask
endmodule

// ### vobc_regs_tb.sv
// Self-checking bench for the overlay config bank
`timescale 1ns/10ps
module vobc_regs_tb;
  import vobc_pkg::*;
  logic              clk_i, nrst_i, frame_start_i, alpha_bit_i, wr, rd;
  logic              rvalid, rerr, en, fb, clp, syn, fsy, gl, key;
  logic [2:0]        mode_i;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata, rdata, luma, cbs, crs, ovls, sbs, rdat, wd, live;
  logic [11:0]       row, col, hgt, wid;
  logic [7:0]        bw;
  logic [23:0]       len1, len2;
  logic [15:0]       yst, cbst, crst, ost;
  logic [1:0]        rv;
  logic [31:0]       m [9];
  int                err_count, num_checks, cyc, seed;

  vobc_regs u_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .reg_err_o(rerr), .mode_i(mode_i),
    .frame_start_i(frame_start_i), .alpha_bit_i(alpha_bit_i),
    .overlay_first_row_o(row), .overlay_first_column_o(col),
    .overlay_height_o(hgt), .overlay_width_o(wid), .blend_weight_o(bw),
    .luma_plane_start_o(luma), .cb_plane_start_o(cbs),
    .cr_plane_start_o(crs), .ovl_plane_start_o(ovls),
    .second_buffer_start_o(sbs), .first_buffer_length_o(len1),
    .second_buffer_length_o(len2), .luma_line_stride_o(yst),
    .cb_line_stride_o(cbst), .cr_line_stride_o(crst),
    .ovl_line_stride_o(ost), .enhanced_features_on_o(en),
    .full_blend_o(fb), .clip_enable_o(clp), .sync_streaming_o(syn),
    .field_sync_o(fsy), .genlock_o(gl), .key_enable_o(key));
  vobc_cpu_model u_cpu (
    .clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
    .reg_err_i(rerr));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // The run needs under 150 cycles; this only catches a hang
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      results();
    end
  end

  task automatic results();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input int i);
    u_cpu.rd(6'(i * 4), rdat, rv);
    chk(rdat, m[i]);
    chk(rv, 2'b01);
  endtask
  task automatic wreg(input int i, input logic [31:0] d);
    u_cpu.wr(6'(i * 4), d);
    m[i] = (i == 8) ? {REVISION, 21'h0, d[6:0]} : d;
  endtask
  task automatic settle();
    repeat (3) u_cpu.idle();
  endtask
  task automatic frame();
    frame_start_i = 1'b1;
    u_cpu.idle();
    frame_start_i = 1'b0;
  endtask
  function automatic logic [7:0] snap(input logic [7:0] w);
    if (w < 8'h20) return 8'h00;
    if (w < 8'h60) return 8'h40;
    if (w < 8'ha0) return 8'h80;
    if (w < 8'he0) return 8'hc0;
    return 8'hff;
  endfunction

  initial begin
    nrst_i = 1'b0;
    mode_i = VOBC_REFRESH;
    frame_start_i = 1'b0;
    alpha_bit_i = 1'b0;
    seed = $urandom(92);
    repeat (10) @(negedge clk_i);
    nrst_i = 1'b1;
    foreach (m[i]) m[i] = 32'h0;
    m[8] = {REVISION, 28'h0};
    for (int i = 0; i < 9; i++) rdchk(i);
    for (int i = 2; i < 8; i++) wreg(i, $urandom);
    wreg(0, $urandom & 32'hffff_efff);
    wreg(1, $urandom & 32'hffff_e3ff);
    rdchk(1);
    for (int i = 0; i < 8; i++) rdchk(i);
    // Unmapped place: write dropped, read zero with an error pulse
    u_cpu.wr(6'h24, $urandom);
    u_cpu.idle();
    chk(rerr, 1'b1);
    u_cpu.rd(6'h24, rdat, rv);
    chk(rdat, 32'h0);
    chk(rv, 2'b11);
    for (int i = 0; i < 9; i++) rdchk(i);
    settle();
    chk({col, row}, m[0][23:0]);
    chk({wid, hgt}, m[1][23:0]);
    chk({crst, cbst}, m[6]);
    chk({ost, yst}, m[7]);
    // An odd column never reaches the datapath
    wreg(0, m[0] | 32'h0000_1000);
    settle();
    chk(col, {m[0][23:13], 1'b0});
    // New overlay start waits for the frame strobe
    frame();
    live = m[5];
    wreg(5, $urandom);
    settle();
    chk(ovls, live);
    frame();
    settle();
    live = m[5];
    chk(ovls, live);
    for (int k = 0; k < 3; k++) begin
      mode_i = 3'(1 << k);
      settle();
      chk(luma, m[2]);
      chk(cbs, k == 0 ? m[3] : 32'h0);
      chk(crs, k == 0 ? m[4] : 32'h0);
      chk(ovls, k == 0 ? live : 32'h0);
      chk(sbs, k == 1 ? m[3] & 32'hffff_ffc0 : 32'h0);
      wd = {8'h0, m[4][23:0] & (k == 1 ? 24'hff_ffc0 : 24'hff_ffff)};
      chk(len1, k == 0 ? 32'h0 : wd);
      chk(len2, k == 1 ? m[5][23:0] & 24'hff_ffc0 : 24'h0);
    end
    // Features without enable, with it, then streaming sync off mode
    for (int k = 0; k < 3; k++) begin
      mode_i = k == 2 ? VOBC_REFRESH : VOBC_STREAM;
      wreg(8, k == 0 ? 32'h7e : 32'h7f);
      settle();
      wd = k == 0 ? 32'h0 : (k == 1 ? 32'h7f : 32'h77);
      chk({key, gl, fsy, syn, clp, fb, en}, wd);
      rdchk(8);
    end
    for (int k = 0; k < 4; k++) begin
      wreg(8, k < 2 ? 32'h3 : (k == 2 ? 32'h2 : 32'h1));
      alpha_bit_i = k[0];
      settle();
      wd = k[0] ? m[0] : m[1];
      chk(bw, k < 2 ? wd[31:24] : snap(wd[31:24]));
    end
    // Second reset in mid-run
    nrst_i = 1'b0;
    u_cpu.idle();
    nrst_i = 1'b1;
    foreach (m[i]) m[i] = 32'h0;
    m[8] = {REVISION, 28'h0};
    rdchk(8);
    chk(en, 1'b0);
    results();
  end
endmodule
